// ==== hw/esac_pkg.sv ====
// shared constants and carrier types for the auxiliary control block
package esac_pkg;

    // special-function addresses
    localparam logic [7:0] AUX1_ADDR = 8'h00_A2;
    localparam logic [7:0] SHARED_ADDR = 8'h00_C0;

    // field positions of auxiliary_control_1
    localparam int EES_BIT = 7;
    localparam int MSB_BIT = 6;
    localparam int MAP_BIT = 5;
    localparam int RSV_HI_BIT = 4;
    localparam int FLAG_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int RSV_LO_BIT = 1;
    localparam int DPS_BIT = 0;

    // reset value, reserved bits taken as zero
    localparam logic [7:0] AUX1_RESET = 8'h00_00;

    // stack pointer limits that carry into or borrow from the ninth bit
    localparam logic [7:0] SP_TOP = 8'h00_FF;
    localparam logic [7:0] SP_BOTTOM = 8'h00_00;
    localparam logic [15:0] DPTR_STEP = 16'h0001;
    localparam logic [15:0] DPTR_RESET = 16'h0000;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic inc;
    } esac_sfr_req_t;

    // stack pointer operation from the core
    typedef struct packed {
        logic [7:0] stack_pointer;
        logic push;
        logic pop;
    } esac_stack_req_t;

    // data pointer operation from the core
    typedef struct packed {
        logic [15:0] load_value;
        logic load;
        logic inc;
    } esac_dptr_req_t;

    // state of the control register block
    typedef struct packed {
        logic stack_extend_enable;
        logic stack_ptr_msb;
        logic port4_map_select;
        logic user_flag_b;
        logic data_pointer_select;
        logic [7:0] rdata;
    } esac_state_t;

    // state of the data pointer bank
    typedef struct packed {
        logic [15:0] data_pointer_first;
        logic [15:0] data_pointer_second;
    } esac_dptr_state_t;

endpackage

// ==== hw/esac_dptr_bank.sv ====
// dual data pointer bank steered by the select bit
`timescale 1ns/1ns
module esac_dptr_bank
    import esac_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic data_pointer_select, // 0 first, 1 second
    input wire esac_dptr_req_t req, // load or increment
    output logic [15:0] dptr_value, // selected pointer
    output logic [15:0] dptr_first_value, // first pointer
    output logic [15:0] dptr_second_value // second pointer
);

    esac_dptr_state_t cur;
    esac_dptr_state_t next_cur;

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        if (req.load)
        begin
            if (data_pointer_select)
                next_cur.data_pointer_second = req.load_value;
            else
                next_cur.data_pointer_first = req.load_value;
        end
        else if (req.inc)
        begin
            if (data_pointer_select)
                next_cur.data_pointer_second = cur.data_pointer_second + DPTR_STEP;
            else
                next_cur.data_pointer_first = cur.data_pointer_first + DPTR_STEP;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cur.data_pointer_first <= DPTR_RESET;
            cur.data_pointer_second <= DPTR_RESET;
        end
        else
            cur <= next_cur;
    end

    assign dptr_value = data_pointer_select ? cur.data_pointer_second : cur.data_pointer_first;
    assign dptr_first_value = cur.data_pointer_first;
    assign dptr_second_value = cur.data_pointer_second;

    ////////////////////////////////////////////////////////////////
    property p_dptr_route;
        @(posedge sys_clk) disable iff (!nrst)
        (req.load && data_pointer_select) |=>
            (dptr_second_value == $past(req.load_value)) &&
            (dptr_first_value == $past(dptr_first_value));
    endproperty
    a_dptr_route: assert property (p_dptr_route) else $error("load reached the wrong data pointer");

    property p_dptr_first;
        @(posedge sys_clk) disable iff (!nrst)
        (req.inc && !req.load && !data_pointer_select) |=>
            (dptr_first_value == $past(dptr_first_value) + DPTR_STEP) &&
            (dptr_second_value == $past(dptr_second_value));
    endproperty
    a_dptr_first: assert property (p_dptr_first) else $error("increment reached the wrong data pointer");

endmodule

// ==== hw/esac_aux_ctrl.sv ====
// auxiliary control register: extended stack, shared address map, pointer select
`timescale 1ns/1ns
module esac_aux_ctrl
    import esac_pkg::*;
(
    input wire logic sys_clk, // core clock, 250 MHz
    input wire logic nrst, // async reset, active low
    input wire esac_sfr_req_t sfr_req, // register port request
    output logic [7:0] sfr_rdata, // read data, cycle after read
    input wire esac_stack_req_t stack_req, // push or pop from core
    output logic [8:0] stack_addr, // effective stack address
    output logic stack_in_expanded_ram, // stack addresses expanded_ram
    input wire esac_dptr_req_t dptr_req, // data pointer operation
    output logic [15:0] dptr_value, // selected data pointer
    output logic [15:0] dptr_first_value, // first data pointer
    output logic [15:0] dptr_second_value, // second data pointer
    output logic sel_serial_ctrl_second, // C0h goes to serial control
    output logic sel_port_four_latch, // C0h goes to port four latch
    output logic stack_extend_enable, // extended stack mode on
    output logic data_pointer_select, // 0 first, 1 second
    output logic user_flag_b // software flag
);

    esac_state_t cur;
    esac_state_t next_cur;
    logic aux_hit;
    logic shared_hit;
    logic ext_push_carry;
    logic ext_pop_borrow;

    ////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    // readback image; reserved bits and bit 2 read as zero
    function automatic logic [7:0] aux_image(input esac_state_t s);
        logic [7:0] v;
        v = AUX1_RESET;
        v[EES_BIT] = s.stack_extend_enable;
        v[MSB_BIT] = s.stack_ptr_msb;
        v[MAP_BIT] = s.port4_map_select;
        v[FLAG_BIT] = s.user_flag_b;
        v[DPS_BIT] = s.data_pointer_select;
        v[ZERO_BIT] = 1'b0;
        v[RSV_HI_BIT] = 1'b0;
        v[RSV_LO_BIT] = 1'b0;
        aux_image = v;
    endfunction

    ////////////////////////////////////////////////////////////////
    // decode

    assign aux_hit = addr_is(sfr_req.addr, AUX1_ADDR);
    assign shared_hit = addr_is(sfr_req.addr, SHARED_ADDR) && (sfr_req.wr || sfr_req.rd || sfr_req.inc);

    // carry out of and borrow into the low eight bits
    assign ext_push_carry = cur.stack_extend_enable && stack_req.push &&
        (stack_req.stack_pointer == SP_TOP);
    assign ext_pop_borrow = cur.stack_extend_enable && stack_req.pop && !stack_req.push &&
        (stack_req.stack_pointer == SP_BOTTOM);

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_cur = cur;
        next_cur.rdata = 8'h00_00;
        if (sfr_req.rd && aux_hit)
        begin
            next_cur.rdata = aux_image(cur);
        end
        if (sfr_req.wr && aux_hit)
        begin
            // the ninth bit is left alone on a software write
            next_cur.stack_extend_enable = sfr_req.wdata[EES_BIT];
            next_cur.port4_map_select = sfr_req.wdata[MAP_BIT];
            next_cur.user_flag_b = sfr_req.wdata[FLAG_BIT];
            next_cur.data_pointer_select = sfr_req.wdata[DPS_BIT];
        end
        else if (sfr_req.inc && aux_hit)
        begin
            // increment flips the select bit, other fields hold
            next_cur.data_pointer_select = !cur.data_pointer_select;
        end
        if (ext_push_carry)
        begin
            next_cur.stack_ptr_msb = 1'b1;
        end
        else if (ext_pop_borrow)
        begin
            next_cur.stack_ptr_msb = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cur.stack_extend_enable <= AUX1_RESET[EES_BIT];
            cur.stack_ptr_msb <= AUX1_RESET[MSB_BIT];
            cur.port4_map_select <= AUX1_RESET[MAP_BIT];
            cur.user_flag_b <= AUX1_RESET[FLAG_BIT];
            cur.data_pointer_select <= AUX1_RESET[DPS_BIT];
            cur.rdata <= AUX1_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata = cur.rdata;

    // ninth bit only counts while extension is on
    assign stack_in_expanded_ram = cur.stack_extend_enable && cur.stack_ptr_msb;
    assign stack_addr = {stack_in_expanded_ram, stack_req.stack_pointer};

    assign sel_serial_ctrl_second = shared_hit && !cur.port4_map_select;
    assign sel_port_four_latch = shared_hit && cur.port4_map_select;

    assign stack_extend_enable = cur.stack_extend_enable;
    assign data_pointer_select = cur.data_pointer_select;
    assign user_flag_b = cur.user_flag_b;

    ////////////////////////////////////////////////////////////////
    // data pointer bank

    esac_dptr_bank u_dptr
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .data_pointer_select(cur.data_pointer_select),
        .req(dptr_req),
        .dptr_value(dptr_value),
        .dptr_first_value(dptr_first_value),
        .dptr_second_value(dptr_second_value)
    );

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_aux_write;
        sfr_req.wr && aux_hit;
    endsequence

    sequence s_aux_read;
        sfr_req.rd && aux_hit;
    endsequence

    sequence s_ext_push_top;
        stack_extend_enable && stack_req.push && (stack_req.stack_pointer == SP_TOP);
    endsequence

    sequence s_ext_pop_bottom;
        stack_extend_enable && stack_req.pop && !stack_req.push &&
            (stack_req.stack_pointer == SP_BOTTOM);
    endsequence

    property p_enable_write;
        s_aux_write |=> (stack_extend_enable == $past(sfr_req.wdata[EES_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable bit did not take write");

    property p_push_sets_msb;
        s_ext_push_top |=> stack_in_expanded_ram || !stack_extend_enable;
    endproperty
    a_push_sets_msb: assert property (p_push_sets_msb) else $error("push past top left ninth bit clear");

    property p_pop_clears_msb;
        s_ext_pop_bottom |=> !stack_in_expanded_ram && !cur.stack_ptr_msb;
    endproperty
    a_pop_clears_msb: assert property (p_pop_clears_msb) else $error("pop below zero left ninth bit set");

    property p_msb_gated;
        !stack_extend_enable |-> !stack_in_expanded_ram && (stack_addr[8] == 1'b0);
    endproperty
    a_msb_gated: assert property (p_msb_gated) else $error("ninth bit used with extension off");

    property p_msb_sw_locked;
        (sfr_req.wr && aux_hit && !stack_req.push && !stack_req.pop) |=>
            cur.stack_ptr_msb == $past(cur.stack_ptr_msb);
    endproperty
    a_msb_sw_locked: assert property (p_msb_sw_locked) else $error("software write changed ninth bit");

    property p_msb_read;
        s_aux_read |=> sfr_rdata[MSB_BIT] == $past(cur.stack_ptr_msb);
    endproperty
    a_msb_read: assert property (p_msb_read) else $error("ninth bit readback wrong");

    property p_shared_map;
        shared_hit |-> (sel_port_four_latch == port4_map_select_q()) &&
            (sel_serial_ctrl_second != sel_port_four_latch);
    endproperty
    a_shared_map: assert property (p_shared_map) else $error("shared address routed wrongly");

    function automatic logic port4_map_select_q();
        port4_map_select_q = cur.port4_map_select;
    endfunction

    property p_bit2_zero;
        s_aux_read |=> (sfr_rdata[ZERO_BIT] == 1'b0) && (sfr_rdata[RSV_HI_BIT] == 1'b0);
    endproperty
    a_bit2_zero: assert property (p_bit2_zero) else $error("bit 2 read as one");

    property p_inc_toggle;
        (sfr_req.inc && aux_hit && !sfr_req.wr) |=>
            (data_pointer_select != $past(data_pointer_select)) &&
            (user_flag_b == $past(user_flag_b));
    endproperty
    a_inc_toggle: assert property (p_inc_toggle) else $error("increment did not toggle select");

    property p_flag_readback;
        (s_aux_write ##1 s_aux_read) |=> sfr_rdata[FLAG_BIT] == $past(sfr_req.wdata[FLAG_BIT], 2);
    endproperty
    a_flag_readback: assert property (p_flag_readback) else $error("user flag readback wrong");

    property p_rdata_one_cycle;
        !sfr_req.rd |=> sfr_rdata == 8'h00_00;
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data held too long");

    // carry, a cycle with no pop, then a read of the register
    sequence s_carry_then_read;
        s_ext_push_top ##1 !stack_req.pop ##1 s_aux_read;
    endsequence

    property p_carry_readback;
        s_carry_then_read |=> sfr_rdata[MSB_BIT] == 1'b1;
    endproperty
    a_carry_readback: assert property (p_carry_readback) else $error("ninth bit not read back after carry");

    property p_write_map;
        s_aux_write |=> cur.port4_map_select == $past(sfr_req.wdata[MAP_BIT]);
    endproperty
    a_write_map: assert property (p_write_map) else $error("map bit did not take write");

    property p_write_flag;
        s_aux_write |=> user_flag_b == $past(sfr_req.wdata[FLAG_BIT]);
    endproperty
    a_write_flag: assert property (p_write_flag) else $error("user flag did not take write");

    property p_write_select;
        s_aux_write |=> data_pointer_select == $past(sfr_req.wdata[DPS_BIT]);
    endproperty
    a_write_select: assert property (p_write_select) else $error("select bit did not take write");

    property p_read_enable;
        s_aux_read |=> sfr_rdata[EES_BIT] == $past(stack_extend_enable);
    endproperty
    a_read_enable: assert property (p_read_enable) else $error("enable bit readback wrong");

    property p_read_map;
        s_aux_read |=> sfr_rdata[MAP_BIT] == $past(cur.port4_map_select);
    endproperty
    a_read_map: assert property (p_read_map) else $error("map bit readback wrong");

    property p_read_select;
        s_aux_read |=> sfr_rdata[DPS_BIT] == $past(data_pointer_select);
    endproperty
    a_read_select: assert property (p_read_select) else $error("select bit readback wrong");

    // with no carry and no borrow the ninth bit must not move, writes included
    property p_msb_hold;
        (!ext_push_carry && !ext_pop_borrow) |=> $stable(cur.stack_ptr_msb);
    endproperty
    a_msb_hold: assert property (p_msb_hold) else $error("ninth bit changed without carry or borrow");

    property p_inc_keeps;
        (sfr_req.inc && aux_hit && !sfr_req.wr) |=> $stable(stack_extend_enable) && $stable(cur.port4_map_select);
    endproperty
    a_inc_keeps: assert property (p_inc_keeps) else $error("increment disturbed other fields");

    property p_reset_image;
        $rose(nrst) |-> !stack_extend_enable && !stack_in_expanded_ram && !data_pointer_select &&
            !user_flag_b && !cur.port4_map_select && (sfr_rdata == 8'h00_00);
    endproperty
    a_reset_image: assert property (p_reset_image) else $error("register not clear after reset");

    property p_dptr_mux;
        dptr_value == (data_pointer_select ? dptr_second_value : dptr_first_value);
    endproperty
    a_dptr_mux: assert property (p_dptr_mux) else $error("selected data pointer wrong");

endmodule

// ==== verif/esac_tb.sv ====
// self-checking bench for the auxiliary control register block
`timescale 1ns/1ns
module testbench;
    import esac_pkg::*;
    logic sys_clk;
    logic nrst;
    esac_sfr_req_t sfr_req;
    esac_stack_req_t stack_req;
    esac_dptr_req_t dptr_req;
    logic [7:0] sfr_rdata;
    logic [8:0] stack_addr;
    logic stack_in_expanded_ram;
    logic [15:0] dptr_value;
    logic [15:0] dptr_first_value;
    logic [15:0] dptr_second_value;
    logic sel_serial_ctrl_second;
    logic sel_port_four_latch;
    logic stack_extend_enable;
    logic data_pointer_select;
    logic user_flag_b;
    int err_total = 0;
    int comparisons = 0;
    logic [7:0] exp_q[$];
    logic rd_q = 1'b0;
    logic [15:0] seed = 16'h0009;
    logic [15:0] e_ptr[2];
    logic [15:0] v;

    esac_aux_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .stack_req(stack_req), .stack_addr(stack_addr), .stack_in_expanded_ram(stack_in_expanded_ram),
        .dptr_req(dptr_req), .dptr_value(dptr_value), .dptr_first_value(dptr_first_value),
        .dptr_second_value(dptr_second_value), .sel_serial_ctrl_second(sel_serial_ctrl_second),
        .sel_port_four_latch(sel_port_four_latch), .stack_extend_enable(stack_extend_enable),
        .data_pointer_select(data_pointer_select), .user_flag_b(user_flag_b));

    always #2 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r, input logic i);
        @(posedge sys_clk);
        sfr_req <= '{a, d, w, r, i};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr(a, d, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        sfr(a, 8'h00, 1'b0, 1'b1, 1'b0);
        exp_q.push_back(e);
    endtask

    task automatic idle();
        sfr(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic stk(input logic [7:0] sp, input logic pu, input logic po);
        @(posedge sys_clk);
        stack_req <= '{sp, pu, po};
        // ends any register strobe of the cycle before
        sfr_req <= '0;
    endtask

    task automatic dp(input logic [15:0] val, input logic ld, input logic inc);
        @(posedge sys_clk);
        dptr_req <= '{val, ld, inc};
        sfr_req <= '0;
    endtask

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // read data watcher: one note per read, compared in the cycle after it
    always @(posedge sys_clk) rd_q <= sfr_req.rd;

    always @(negedge sys_clk)
    begin
        if (rd_q)
        begin
            if (exp_q.size() == 0)
                chk("read note", 16'h0001, 16'h0000);
            else
                chk("sfr_rdata", sfr_rdata, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        sfr_req = '0;
        stack_req = '0;
        dptr_req = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rdx(AUX1_ADDR, 8'h00);
        idle();
        #1 chk("enable", stack_extend_enable, 0);
        chk("select", data_pointer_select, 0);
        chk("flag", user_flag_b, 0);
        chk("in_expanded_ram", stack_in_expanded_ram, 0);
        chk("dptr", dptr_value, 16'h0000);
        tdone("reset");
        // every writable bit set, reserved bits kept clear; read-only and constant bits must not follow
        wr(AUX1_ADDR, 8'hED);
        rdx(AUX1_ADDR, 8'hA9);
        idle();
        #1 chk("enable", stack_extend_enable, 1);
        chk("select", data_pointer_select, 1);
        chk("flag", user_flag_b, 1);
        chk("in_expanded_ram", stack_in_expanded_ram, 0);
        wr(8'h55, 8'h00);
        rdx(8'h55, 8'h00);
        rdx(AUX1_ADDR, 8'hA9);
        tdone("write");
        // back-to-back increments toggle the select bit
        sfr(AUX1_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
        sfr(AUX1_ADDR, 8'h00, 1'b0, 1'b0, 1'b1);
        #1 chk("select", data_pointer_select, 0);
        idle();
        #1 chk("select", data_pointer_select, 1);
        rdx(AUX1_ADDR, 8'hA9);
        wr(AUX1_ADDR, 8'h08);
        rdx(AUX1_ADDR, 8'h08);
        idle();
        #1 chk("flag", user_flag_b, 1);
        chk("enable", stack_extend_enable, 0);
        tdone("increment");
        // stack carry and borrow in extended mode
        wr(AUX1_ADDR, 8'h80);
        stk(8'hFE, 1'b1, 1'b0);
        stk(8'hFF, 1'b1, 1'b0);
        #1 chk("in_expanded_ram", stack_in_expanded_ram, 0);
        stk(8'hFF, 1'b0, 1'b0);
        #1 chk("in_expanded_ram", stack_in_expanded_ram, 1);
        chk("stack_addr", stack_addr, 16'h01FF);
        rdx(AUX1_ADDR, 8'hC0);
        stk(8'h01, 1'b0, 1'b1);
        stk(8'h00, 1'b0, 1'b1);
        #1 chk("in_expanded_ram", stack_in_expanded_ram, 1);
        stk(8'h00, 1'b0, 1'b0);
        #1 chk("in_expanded_ram", stack_in_expanded_ram, 0);
        chk("stack_addr", stack_addr, 16'h0000);
        stk(8'hFF, 1'b1, 1'b0);
        stk(8'hFF, 1'b0, 1'b0);
        wr(AUX1_ADDR, 8'h00);
        rdx(AUX1_ADDR, 8'h40);
        idle();
        #1 chk("in_expanded_ram", stack_in_expanded_ram, 0);
        chk("stack_addr", stack_addr, 16'h00FF);
        tdone("stack");
        // reset in mid-run clears everything again
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        stk(8'hFF, 1'b1, 1'b0);
        stk(8'hFF, 1'b0, 1'b0);
        rdx(AUX1_ADDR, 8'h00);
        wr(AUX1_ADDR, 8'h80);
        rdx(AUX1_ADDR, 8'h80);
        tdone("second reset");
        // shared address steering
        wr(AUX1_ADDR, 8'h00);
        rdx(SHARED_ADDR, 8'h00);
        #1 chk("serial sel", sel_serial_ctrl_second, 1);
        chk("port sel", sel_port_four_latch, 0);
        wr(AUX1_ADDR, 8'h20);
        rdx(SHARED_ADDR, 8'h00);
        #1 chk("port sel", sel_port_four_latch, 1);
        chk("serial sel", sel_serial_ctrl_second, 0);
        idle();
        tdone("shared address");
        // data pointers with random values
        e_ptr[0] = 16'h0000;
        e_ptr[1] = 16'h0000;
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr_next(seed);
            v = seed;
            wr(AUX1_ADDR, 8'(i & 1));
            idle();
            dp(v, 1'b1, 1'b0);
            dp(v, 1'b0, 1'b1);
            dp(v, 1'b0, 1'b0);
            e_ptr[i & 1] = v + DPTR_STEP;
            #1 chk("dptr first", dptr_first_value, e_ptr[0]);
            chk("dptr second", dptr_second_value, e_ptr[1]);
            chk("dptr selected", dptr_value, e_ptr[i & 1]);
        end
        tdone("data pointers");
        for (int n = 0; n < 10 && exp_q.size() != 0; n++)
            @(posedge sys_clk);
        if (exp_q.size() != 0)
            err_total++;
        print_verdict();
    end
endmodule
